// file: design/php_pkg.sv
// constants for the palette host write port
package php_pkg;
    // ----------------------------------------------------------------
    // select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_ADDR_PW = 3'h0;
    localparam logic [2:0] SEL_PAL = 3'h1;
    localparam logic [2:0] SEL_MASK = 3'h2;
    localparam logic [2:0] SEL_ADDR_PR = 3'h3;
    localparam logic [2:0] SEL_ADDR_OW = 3'h4;
    localparam logic [2:0] SEL_OVL = 3'h5;
    localparam logic [2:0] SEL_CTRL = 3'h6;
    localparam logic [2:0] SEL_ADDR_OR = 3'h7;
    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int WORD_W = 24;
    localparam int PAL_DEPTH = 256;
    localparam int OVL_DEPTH = 16;
    localparam logic [1:0] PH_RED = 2'h0;
    localparam logic [1:0] PH_GREEN = 2'h1;
    localparam logic [1:0] PH_BLUE = 2'h2;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] ADDR_TOP = 8'hff;
    localparam logic [7:0] ADDR_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    typedef enum logic [1:0] {MODE_PAL_W, MODE_PAL_R, MODE_OVL_W, MODE_OVL_R} php_mode_t;
endpackage : php_pkg

// file: design/php_port.sv
// host byte port to palette ram, overlay colours and control bytes
//
// What this block does
// [R1] host drives select inputs; block decodes address, palette or control target
// [R2] one 8-bit address register addresses palette and overlay entries
// [R3] address bit zero sits on data bus bit zero, order preserved
// [R4] host loads address, then writes red, green, blue with palette selected
// [R5] after blue write the three bytes form one 24-bit word stored
// [R6] after storing the word the address register increments by one
// [R7] host fills a run by one start address and repeated triples
// [R8] select codes map address modes, palette, mask, overlay and control
// [R9] hidden modulo-three phase counter cleared by address write, not by read
// [R10] blue palette access at top wraps to zero; control accesses do not
// [R11] read-mode load and each blue read copy entry and increment address
// [R12] red and green bytes are staged until blue completes the triple
`timescale 1ns/10ps
module php_port
    import php_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // host strobes, asynchronous pins
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [2:0] i_register_select_inputs,
    input wire logic [7:0] i_data,
    // host data bus
    output logic [7:0] o_data,
    output logic o_data_oe,
    // control register byte port
    output logic o_ctrl_we,
    output logic [7:0] o_ctrl_addr,
    output logic [7:0] o_ctrl_wdata,
    input wire logic [7:0] i_ctrl_rdata,
    // pixel side lookup
    input wire logic [7:0] i_pix_index,
    output logic [23:0] o_pix_colour,
    output logic [7:0] o_pix_mask
);
    // ----------------------------------------------------------------
    // pin synchronisers and strobe edges
    // ----------------------------------------------------------------
    logic rd_s1_r, rd_s2_r, wr_s1_r, wr_s2_r;
    logic [2:0] sel_s1_r, sel_s2_r;
    logic [7:0] dat_s1_r, dat_s2_r;
    logic rd_d_r, wr_d_r;
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_s1_r <= 1'b1;
            rd_s2_r <= 1'b1;
            wr_s1_r <= 1'b1;
            wr_s2_r <= 1'b1;
            sel_s1_r <= SEL_ADDR_PW;
            sel_s2_r <= SEL_ADDR_PW;
            dat_s1_r <= BYTE_ZERO;
            dat_s2_r <= BYTE_ZERO;
            rd_d_r <= 1'b1;
            wr_d_r <= 1'b1;
        end
        else
        begin
            rd_s1_r <= i_rd_n;
            rd_s2_r <= rd_s1_r;
            wr_s1_r <= i_wr_n;
            wr_s2_r <= wr_s1_r;
            sel_s1_r <= i_register_select_inputs;
            sel_s2_r <= sel_s1_r;
            dat_s1_r <= i_data;
            dat_s2_r <= dat_s1_r;
            rd_d_r <= rd_s2_r;
            wr_d_r <= wr_s2_r;
        end
    end
    // write acts at strobe release, read side effects at read release
    logic wr_evt, rd_evt, rd_act;
    assign wr_evt = wr_s2_r & ~wr_d_r;
    assign rd_evt = rd_s2_r & ~rd_d_r;
    assign rd_act = ~rd_s2_r;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [23:0] pal_mem [0:PAL_DEPTH-1];
    logic [23:0] ovl_mem [0:OVL_DEPTH-1];

    // ----------------------------------------------------------------
    // address, phase, staging and holding state
    // ----------------------------------------------------------------
    logic [7:0] addr_r, addr_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [7:0] red_r, red_nxt, grn_r, grn_nxt, mask_r, mask_nxt;
    logic [23:0] hold_r, hold_nxt;
    logic pal_we, ovl_we, ctrl_we;
    logic [23:0] word;
    logic [7:0] rd_byte;
    logic [7:0] inc_addr;
    assign inc_addr = addr_r + ADDR_ONE;
    // [R5] concatenate staged bytes
    assign word = {red_r, grn_r, dat_s2_r};
    always_comb
    begin
        addr_nxt = addr_r;
        phase_nxt = phase_r;
        red_nxt = red_r;
        grn_nxt = grn_r;
        mask_nxt = mask_r;
        hold_nxt = hold_r;
        pal_we = 1'b0;
        ovl_we = 1'b0;
        ctrl_we = 1'b0;
        // [R1] [R8] select decode
        if (wr_evt)
        begin
            case (sel_s2_r)
                SEL_ADDR_PW, SEL_ADDR_PR, SEL_ADDR_OW, SEL_ADDR_OR:
                begin
                    // [R2] [R3] [R9] address load clears phase
                    addr_nxt = dat_s2_r;
                    phase_nxt = PH_RED;
                    // [R11] read mode prefetch
                    if (sel_s2_r == SEL_ADDR_PR)
                    begin
                        hold_nxt = pal_mem[dat_s2_r];
                        addr_nxt = dat_s2_r + ADDR_ONE;
                    end
                    else if (sel_s2_r == SEL_ADDR_OR)
                    begin
                        hold_nxt = ovl_mem[dat_s2_r[3:0]];
                        addr_nxt = dat_s2_r + ADDR_ONE;
                    end
                end
                SEL_PAL, SEL_OVL:
                begin
                    // [R12] stage red and green
                    if (phase_r == PH_RED)
                    begin
                        red_nxt = dat_s2_r;
                        phase_nxt = PH_GREEN;
                    end
                    else if (phase_r == PH_GREEN)
                    begin
                        grn_nxt = dat_s2_r;
                        phase_nxt = PH_BLUE;
                    end
                    else
                    begin
                        // [R5] [R6] [R10] commit and increment, wrapping at top
                        pal_we = (sel_s2_r == SEL_PAL);
                        ovl_we = (sel_s2_r == SEL_OVL);
                        phase_nxt = PH_RED;
                        addr_nxt = inc_addr;
                    end
                end
                SEL_MASK:
                    mask_nxt = dat_s2_r;
                SEL_CTRL:
                begin
                    // [R10] no wrap at top for control bytes
                    ctrl_we = 1'b1;
                    if (addr_r != ADDR_TOP)
                        addr_nxt = inc_addr;
                end
                default:
                    mask_nxt = mask_r;
            endcase
        end
        else if (rd_evt)
        begin
            case (sel_s2_r)
                SEL_PAL, SEL_OVL:
                begin
                    if (phase_r == PH_BLUE)
                    begin
                        // [R11] refill holding and increment after blue read
                        phase_nxt = PH_RED;
                        hold_nxt = (sel_s2_r == SEL_PAL) ? pal_mem[addr_r] :
                                   ovl_mem[addr_r[3:0]];
                        addr_nxt = inc_addr;
                    end
                    else
                        phase_nxt = phase_r + 2'h1;
                end
                SEL_CTRL:
                begin
                    if (addr_r != ADDR_TOP)
                        addr_nxt = inc_addr;
                end
                default:
                    phase_nxt = phase_r;
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            addr_r <= ADDR_RST;
            phase_r <= PH_RED;
            red_r <= BYTE_ZERO;
            grn_r <= BYTE_ZERO;
            mask_r <= MASK_RST;
            hold_r <= 24'h000000;
        end
        else
        begin
            addr_r <= addr_nxt;
            phase_r <= phase_nxt;
            red_r <= red_nxt;
            grn_r <= grn_nxt;
            mask_r <= mask_nxt;
            hold_r <= hold_nxt;
        end
    end
    // palette and overlay arrays, no reset
    always_ff @(posedge i_clk)
    begin
        if (pal_we)
            pal_mem[addr_r] <= word;
        if (ovl_we)
            ovl_mem[addr_r[3:0]] <= word;
    end

    // ----------------------------------------------------------------
    // read data, control port and pixel lookup
    // ----------------------------------------------------------------
    always_comb
    begin
        case (sel_s2_r)
            SEL_ADDR_PW, SEL_ADDR_PR, SEL_ADDR_OW, SEL_ADDR_OR:
                rd_byte = addr_r;
            SEL_PAL, SEL_OVL:
                rd_byte = (phase_r == PH_RED) ? hold_r[23:16] :
                          (phase_r == PH_GREEN) ? hold_r[15:8] : hold_r[7:0];
            SEL_MASK:
                rd_byte = mask_r;
            SEL_CTRL:
                rd_byte = i_ctrl_rdata;
            default:
                rd_byte = BYTE_ZERO;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_data <= BYTE_ZERO;
            o_data_oe <= 1'b0;
            o_ctrl_we <= 1'b0;
            o_ctrl_addr <= ADDR_RST;
            o_ctrl_wdata <= BYTE_ZERO;
            o_pix_colour <= 24'h000000;
        end
        else
        begin
            o_data <= rd_byte;
            o_data_oe <= rd_act;
            o_ctrl_we <= ctrl_we;
            o_ctrl_addr <= addr_r;
            o_ctrl_wdata <= dat_s2_r;
            o_pix_colour <= pal_mem[i_pix_index & mask_r];
        end
    end
    assign o_pix_mask = mask_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_PHASE_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R9]
        (wr_evt && sel_s2_r == SEL_ADDR_PW) |=> phase_r == PH_RED)
        else $error("phase not cleared by address write");
    AST_BLUE_INC: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R6]
        (wr_evt && sel_s2_r == SEL_PAL && phase_r == PH_BLUE) |=> addr_r == $past(addr_r) + ADDR_ONE)
        else $error("address not incremented after blue");
    AST_STAGE_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R12]
        (wr_evt && sel_s2_r == SEL_PAL && phase_r != PH_BLUE) |-> !pal_we)
        else $error("palette written before blue");
    AST_COMMIT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R5]
        (wr_evt && sel_s2_r == SEL_PAL && phase_r == PH_BLUE) |-> pal_we)
        else $error("blue write not committed");
    AST_CTRL_NOWRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
        (wr_evt && sel_s2_r == SEL_CTRL && addr_r == ADDR_TOP) |=> addr_r == ADDR_TOP)
        else $error("control address wrapped");
    AST_PAL_WRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
        (wr_evt && sel_s2_r == SEL_PAL && phase_r == PH_BLUE && addr_r == ADDR_TOP)
        |=> addr_r == ADDR_RST)
        else $error("palette address did not wrap");
    AST_RD_PREFETCH: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R11]
        (wr_evt && sel_s2_r == SEL_ADDR_PR) |=> addr_r == $past(dat_s2_r) + ADDR_ONE)
        else $error("read mode load did not increment");
    AST_ADDR_LOAD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
        (wr_evt && sel_s2_r == SEL_ADDR_PW) |=> addr_r == $past(dat_s2_r))
        else $error("address not loaded");
endmodule : php_port

// file: test/php_host_model.sv
// host bus model driving the palette port pins
`timescale 1ns/10ps
module php_host_model
    import php_pkg::*;
(
    // clock
    input wire logic i_clk,
    // host pins
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [2:0] o_sel,
    output logic [7:0] o_data,
    input wire logic [7:0] i_data
);
    initial
    begin
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_sel = SEL_ADDR_PW;
        o_data = 8'h00;
    end
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(negedge i_clk);
        o_sel = sel;
        o_data = d;
        o_wr_n = 1'b0;
        repeat (5) @(negedge i_clk);
        o_wr_n = 1'b1;
        repeat (4) @(negedge i_clk);
        o_data = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] sel, output logic [7:0] d);
        @(negedge i_clk);
        o_sel = sel;
        o_rd_n = 1'b0;
        repeat (5) @(negedge i_clk);
        d = i_data;
        o_rd_n = 1'b1;
        repeat (5) @(negedge i_clk);
    endtask : rd
    task automatic triple(input logic [2:0] sel, input logic [23:0] c);
        wr(sel, c[23:16]);
        wr(sel, c[15:8]);
        wr(sel, c[7:0]);
    endtask : triple
endmodule : php_host_model

// file: test/tb_palette_host_write_port.sv
// testbench for the palette host write port
`timescale 1ns/10ps
module tb_palette_host_write_port;
    import php_pkg::*;
    logic i_clk, i_resetn, i_rd_n, i_wr_n, o_data_oe, o_ctrl_we;
    logic [2:0] i_sel;
    logic [7:0] i_data, o_data, o_ctrl_addr, o_ctrl_wdata, i_pix_index, o_pix_mask, b;
    logic [23:0] o_pix_colour;
    logic [7:0] i_ctrl_rdata;
    logic [7:0] we_addr = 8'h00;
    int oe_cnt = 0;
    logic [7:0] we_data = 8'h00;
    int n_fail = 0;
    int samples_checked = 0;
    int we_cnt = 0;
    php_port i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
        .i_register_select_inputs(i_sel), .i_data(i_data), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_ctrl_we(o_ctrl_we), .o_ctrl_addr(o_ctrl_addr),
        .o_ctrl_wdata(o_ctrl_wdata), .i_ctrl_rdata(i_ctrl_rdata), .i_pix_index(i_pix_index),
        .o_pix_colour(o_pix_colour), .o_pix_mask(o_pix_mask));
    php_host_model i_host (.i_clk(i_clk), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_sel(i_sel),
        .o_data(i_data), .i_data(o_data));
    // control register stand-in: read byte depends on the address read
    assign i_ctrl_rdata = o_ctrl_addr ^ 8'h5a;
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(negedge i_clk)
    begin
        if (o_ctrl_we === 1'b1)
        begin
            we_cnt <= we_cnt + 1;
            we_data <= o_ctrl_wdata;
            we_addr <= o_ctrl_addr;
        end
        if (o_data_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pix(input logic [7:0] idx, input logic [23:0] exp);
        @(negedge i_clk);
        i_pix_index = idx;
        repeat (4) @(negedge i_clk);
        chk(o_pix_colour, exp);
    endtask : pix
    task automatic t_pal_write;
        i_host.wr(SEL_ADDR_PW, 8'h05);
        i_host.triple(SEL_PAL, 24'ha1b2c3);
        i_host.triple(SEL_PAL, 24'hd4e5f6);
        pix(8'h05, 24'ha1b2c3);
        pix(8'h06, 24'hd4e5f6);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'h07);
        i_host.wr(SEL_ADDR_PW, 8'h05);
        i_host.wr(SEL_PAL, 8'h11);
        i_host.wr(SEL_PAL, 8'h22);
        pix(8'h05, 24'ha1b2c3);
        i_host.wr(SEL_PAL, 8'h33);
        pix(8'h05, 24'h112233);
        i_host.wr(SEL_ADDR_PW, 8'hff);
        i_host.triple(SEL_PAL, 24'h0a0b0c);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'h00);
        pix(8'hff, 24'h0a0b0c);
    endtask : t_pal_write
    task automatic t_phase;
        i_host.wr(SEL_ADDR_PW, 8'h10);
        i_host.wr(SEL_PAL, 8'hee);
        i_host.wr(SEL_ADDR_PW, 8'h10);
        i_host.triple(SEL_PAL, 24'h123456);
        pix(8'h10, 24'h123456);
        i_host.wr(SEL_ADDR_PW, 8'h20);
        i_host.wr(SEL_PAL, 8'h77);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'h20);
        i_host.wr(SEL_PAL, 8'h88);
        i_host.wr(SEL_PAL, 8'h99);
        pix(8'h20, 24'h778899);
    endtask : t_phase
    task automatic t_pal_read;
        logic [23:0] exp [2];
        exp[0] = 24'h112233;
        exp[1] = 24'hd4e5f6;
        i_host.wr(SEL_ADDR_PR, 8'h05);
        for (int e = 0; e < 2; e++)
        begin
            for (int k = 2; k >= 0; k--)
            begin
                i_host.rd(SEL_PAL, b);
                chk(b, exp[e][8*k+:8]);
            end
        end
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'h08);
    endtask : t_pal_read
    task automatic t_mask_ovl;
        i_host.wr(SEL_MASK, 8'h0f);
        chk(o_pix_mask, 8'h0f);
        pix(8'hf5, 24'h112233);
        i_host.wr(SEL_MASK, 8'hff);
        i_host.wr(SEL_ADDR_OW, 8'h03);
        i_host.triple(SEL_OVL, 24'h6c7d8e);
        i_host.wr(SEL_ADDR_OR, 8'h03);
        for (int k = 2; k >= 0; k--)
        begin
            i_host.rd(SEL_OVL, b);
            chk(b, 24'h6c7d8e >> (8 * k) & 24'hff);
        end
    endtask : t_mask_ovl
    task automatic t_ctrl;
        int oe_start;
        i_host.wr(SEL_ADDR_PW, 8'hfe);
        i_host.wr(SEL_CTRL, 8'h3c);
        chk(we_cnt, 1);
        chk(we_data, 8'h3c);
        chk(we_addr, 8'hfe);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'hff);
        oe_start = oe_cnt;
        i_host.rd(SEL_CTRL, b);
        chk(b, 8'hff ^ 8'h5a);
        chk(oe_cnt - oe_start, 5);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'hff);
        i_host.wr(SEL_CTRL, 8'h4b);
        chk(we_cnt, 2);
        chk(we_addr, 8'hff);
        chk(we_data, 8'h4b);
        i_host.rd(SEL_ADDR_PW, b);
        chk(b, 8'hff);
    endtask : t_ctrl
    task automatic stop_test;
        $display("checks=%0d failures=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial
    begin
        i_resetn = 1'b0;
        i_pix_index = 8'h00;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1'b1;
        chk(o_pix_mask, MASK_RST);
        chk(o_data_oe, 1'b0);
        repeat (3) @(negedge i_clk);
        t_pal_write();
        t_phase();
        t_pal_read();
        t_mask_ovl();
        t_ctrl();
        stop_test();
    end
endmodule : tb_palette_host_write_port
